/* File: testbench/phy_link_model.sv */
// PHY side model that feeds indicate bytes into the ring engine block.
// Assumes the bench changes the wanted byte on a rising edge; the model
// moves it onto the pins at the following falling edge.
`timescale 1ns/1ps
module phy_link_model (
    // Clock.
    input wire logic clk_in,
    // Byte to send and a command to spoil its parity.
    input wire logic [7:0] byte_in,
    input wire logic spoil_in,
    // Indicate pins of the block.
    output ring_mode_pkg::par_byte_t pins_out
);
    import ring_mode_pkg::*;

    // --------------------------------------------------------------
    // Pin driver
    // --------------------------------------------------------------
    // A healthy PHY always sends odd parity.
    // Bad parity only appears when a scenario asks for it.
    // One process owns the pins; they settle on the first falling edge,
    // well inside the reset, so nothing unknown reaches the block.
    always @(negedge clk_in) begin
        pins_out.data <= byte_in;
        pins_out.parity <= (~^byte_in) ^ spoil_in;
    end
endmodule

/* File: testbench/ring_engine_mode_parity_control_bench.sv */
// Self-checking bench for the ring engine mode and parity control block.
// Assumes the package, the constants header and the PHY model are built
// first; inputs change on the falling edge of the clock.
`timescale 1ns/1ps
`include "ring_mode_cfg.svh"
module ring_engine_mode_parity_control_bench;
    import ring_mode_pkg::*;

    logic sys_clk_in, sys_rst_in, clk_en_in, mac_valid, cv, abort, oe;
    logic run, diagnose_mode_enable, link_spoil;
    logic [7:0] link_byte, rd_val;
    logic [`TIMER_WIDTH-1:0] timer;
    par_byte_t phy_ind, mac_req, cb_data, phy_req, mac_ind, rdata;
    cbus_req_t cb_req;
    int fail_count = 0;
    int total_checks = 0;

    // ----------------------------------------------------------------
    // Clock, partner and block
    // ----------------------------------------------------------------
    // The 4 ns clock period gives the 250 MHz system rate.
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    phy_link_model phy (.clk_in(sys_clk_in), .byte_in(link_byte),
        .spoil_in(link_spoil), .pins_out(phy_ind));

    ring_mode_ctrl uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .phy_indicate_data_pins_in(phy_ind),
        .mac_request_data_pins_in(mac_req),
        .mac_request_valid_in(mac_valid), .cbus_req_in(cb_req),
        .control_bus_data_pins_in(cb_data),
        .phy_request_data_pins_out(phy_req),
        .mac_indicate_data_pins_out(mac_ind), .code_violation_out(cv),
        .tx_abort_out(abort), .control_bus_rdata_out(rdata),
        .control_bus_data_oe_out(oe), .run_mode_out(run),
        .diagnose_mode_enable_out(diagnose_mode_enable), .ring_timer_out(timer));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Compares one value and counts it.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A write holds wr long enough to cross the input synchronisers,
    // then keeps it low so the next write is seen as a new one.
    task automatic cbus_write(input logic [8:0] a, input logic [7:0] d,
                              input logic spoil);
        @(negedge sys_clk_in);
        cb_req = '{wr: 1'b1, rd: 1'b0, addr: a};
        cb_data = '{parity: (~^d) ^ spoil, data: d};
        repeat (4) @(negedge sys_clk_in);
        cb_req.wr = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask

    // A read waits a bounded time for the drive enable, checks parity.
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge sys_clk_in);
        cb_req = '{wr: 1'b0, rd: 1'b1, addr: a};
        while (oe !== 1'b1 && n < 10) begin
            @(negedge sys_clk_in);
            n++;
        end
        @(negedge sys_clk_in);
        check(16'(oe), 16'h0001);
        check(16'(^rdata), 16'h0001);
        check(16'(rdata.data), 16'(exp));
        cb_req.rd = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask

    // The byte change lands on a rising edge so the model never races.
    task automatic send_link(input logic [7:0] b, input logic spoil);
        @(posedge sys_clk_in);
        link_byte <= b;
        link_spoil <= spoil;
        repeat (6) @(negedge sys_clk_in);
    endtask

    task automatic mac_send(input logic [7:0] b, input logic spoil,
                            input logic valid);
        @(negedge sys_clk_in);
        mac_req = '{parity: (~^b) ^ spoil, data: b};
        mac_valid = valid;
        repeat (6) @(negedge sys_clk_in);
    endtask

    task automatic timer_step(input logic [15:0] delta);
        logic [15:0] t0;
        t0 = timer;
        repeat (10) @(negedge sys_clk_in);
        check(timer - t0, delta);
    endtask

    // The abort is a one-cycle pulse, so every cycle is looked at.
    task automatic abort_watch(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(negedge sys_clk_in);
            if (abort === 1'b1) begin
                seen = 1'b1;
            end
        end
        check(16'(seen), 16'(exp));
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    // The whole sequence needs far fewer than 25000 cycles.
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial begin
        sys_rst_in = 1'b1;
        clk_en_in = 1'b1;
        cb_req = '0;
        cb_data = '0;
        mac_req = '0;
        mac_valid = 1'b0;
        link_byte = 8'hFF;
        link_spoil = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        rd_chk(`MODE_REG_ADDR, 8'h00);
        rd_chk(`OPTION_REG_ADDR, 8'h00);
        check(16'(phy_req), 16'h01FF);
        timer_step(16'h0000);
        cbus_write(`OPTION_REG_ADDR, 8'h5A, 1'b0);
        rd_chk(`OPTION_REG_ADDR, 8'h5A);
        // Run with indicate parity checking only.
        cbus_write(`MODE_REG_ADDR, 8'h09, 1'b0);
        check(16'(run), 16'h0001);
        timer_step(16'h000A);
        cbus_write(`OPTION_REG_ADDR, 8'hA5, 1'b1);
        rd_chk(`OPTION_REG_ADDR, 8'hA5);
        send_link(8'h42, 1'b0);
        check(16'(phy_req), {7'h00, ~^8'h42, 8'h42});
        check(16'(^mac_ind), 16'h0001);
        send_link(8'h42, 1'b1);
        check(16'(phy_req), 16'h01FF);
        check(16'(cv), 16'h0001);
        check(16'(mac_ind.data), 16'h00FF);
        // Without checking, a spoiled parity is repeated as it came.
        cbus_write(`MODE_REG_ADDR, 8'h01, 1'b0);
        send_link(8'h42, 1'b1);
        check(16'(phy_req), {7'h00, ^8'h42, 8'h42});
        check(16'(cv), 16'h0000);
        mac_send(8'h3C, 1'b1, 1'b1);
        check(16'(phy_req), {7'h00, ~^8'h3C, 8'h3C});
        abort_watch(1'b0);
        mac_send(8'h3C, 1'b0, 1'b0);
        // Control bus and MAC request checking on.
        cbus_write(`MODE_REG_ADDR, 8'h07, 1'b0);
        mac_send(8'h3C, 1'b0, 1'b1);
        check(16'(phy_req), {7'h00, ~^8'h3C, 8'h3C});
        mac_req.parity = ^8'h3C;
        abort_watch(1'b1);
        mac_send(8'h3C, 1'b0, 1'b0);
        cbus_write(`MODE_REG_ADDR, 8'h00, 1'b1);
        check(16'(run), 16'h0001);
        rd_chk(`MODE_REG_ADDR, 8'h07);
        rd_chk(`EXC_STATUS_ADDR, 8'h01);
        rd_chk(`STATE_ATTN_ADDR, 8'h00);
        cbus_write(`STATE_ATTN_ADDR, 8'h00, 1'b1);
        rd_chk(`STATE_ATTN_ADDR, 8'h01);
        cbus_write(`EXC_STATUS_ADDR, 8'h01, 1'b0);
        cbus_write(`STATE_ATTN_ADDR, 8'h01, 1'b0);
        rd_chk(`EXC_STATUS_ADDR, 8'h00);
        rd_chk(`STATE_ATTN_ADDR, 8'h00);
        rd_chk(9'h055, 8'h00);
        // Reserved bits stay zero; the diagnose bit reaches its output.
        cbus_write(`MODE_REG_ADDR, 8'hB9, 1'b0);
        rd_chk(`MODE_REG_ADDR, 8'h89);
        check(16'(diagnose_mode_enable), 16'h0001);
        // Loopback: the PHY pins are ignored, request bytes come back.
        cbus_write(`MODE_REG_ADDR, 8'h41, 1'b0);
        send_link(8'h42, 1'b0);
        check(16'(mac_ind.data), 16'h00FF);
        mac_send(8'h3C, 1'b0, 1'b1);
        mac_send(8'h3C, 1'b0, 1'b0);
        check(16'(mac_ind.data), 16'h003C);
        check(16'(phy_req), 16'h013C);
        cbus_write(`MODE_REG_ADDR, 8'h00, 1'b0);
        check(16'(run), 16'h0000);
        check(16'(phy_req), 16'h01FF);
        timer_step(16'h0000);
        // A second reset, given in stop mode, clears the written option register.
        sys_rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        rd_chk(`OPTION_REG_ADDR, 8'h00);
        check(16'(phy_req), 16'h01FF);
        give_verdict();
    end
endmodule

/* File: verilog/ring_mode_cfg.svh */
// Constants for the ring engine mode and parity control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RING_MODE_CFG_SVH
`define RING_MODE_CFG_SVH
// ------------------------------------------------------------
// Register addresses on the control bus.
// ------------------------------------------------------------
`define MODE_REG_ADDR 9'h000
`define OPTION_REG_ADDR 9'h001
`define EXC_STATUS_ADDR 9'h12C
`define STATE_ATTN_ADDR 9'h106
`define ADDR_BLOCK_BIT 8
// ------------------------------------------------------------
// Mode register fields and reset values.
// ------------------------------------------------------------
`define MODE_RUN_BIT 0
`define MODE_CBUS_PAR_BIT 1
`define MODE_MREQ_PAR_BIT 2
`define MODE_PIND_PAR_BIT 3
`define MODE_LOOP_BIT 6
`define MODE_DIAGNOSE_MODE_ENABLE_BIT 7
`define MODE_WRITE_MASK 8'hCF
`define MODE_RESET 8'h00
`define OPTION_RESET 8'h00
`define CPE_BIT 0
`define IDLE_BYTE 8'hFF
`define TIMER_WIDTH 16
`endif

/* File: verilog/ring_mode_ctrl.sv */
// Ring engine mode register with parity checking and run/stop control.
// Assumes pins arrive asynchronously and are synchronised here.
// Summary of operation
// - Mode bit 3 enables odd parity check on incoming PHY indicate bytes.
// - A bad indicate byte counts as a code violation and becomes Idle.
// - When repeating, indicate parity is passed unchanged to request parity.
// - Internally made bytes get odd parity; request parity is always driven.
// - Mode bit 2 enables odd parity check on MAC request data.
// - A MAC request parity error aborts the frame being sent.
// - Odd parity is always generated on the MAC indicate parity output.
// - Mode bit 1 enables odd parity check on control bus writes.
// - Bad write with address bit 8 low flags exception status.
// - Bad write with address bit 8 high flags state attention.
// - A write with bad parity leaves the target register untouched, except state attention, whose flag it sets.
// - Every control bus read drives valid odd parity with the data.
// - Run bit low forces all state machines to their zero state.
// - In stop mode counters and timers do not advance.
// - In stop mode only Idle symbols go out on PHY request.
// - Run bit high enables normal MAC operation.
// - Master reset clears the option register to zero.
// - Option changes are accepted while the engine runs.
// - Mode bit 6 loops request data back to indicate inputs.
// - Mode bit 7 drives the diagnose mode enable output.
`timescale 1ns/1ps
`include "ring_mode_cfg.svh"
module ring_mode_ctrl (
    // Clock, reset and enable.
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // PHY indicate pins.
    input wire ring_mode_pkg::par_byte_t phy_indicate_data_pins_in,
    // MAC request pins from the system side.
    input wire ring_mode_pkg::par_byte_t mac_request_data_pins_in,
    input wire logic mac_request_valid_in,
    // Control bus pins.
    input wire ring_mode_pkg::cbus_req_t cbus_req_in,
    input wire ring_mode_pkg::par_byte_t control_bus_data_pins_in,
    // PHY request pins.
    output ring_mode_pkg::par_byte_t phy_request_data_pins_out,
    // MAC indicate pins towards the system side.
    output ring_mode_pkg::par_byte_t mac_indicate_data_pins_out,
    output logic code_violation_out,
    output logic tx_abort_out,
    // Control bus read side, open drive.
    output ring_mode_pkg::par_byte_t control_bus_rdata_out,
    output logic control_bus_data_oe_out,
    // Mode status.
    output logic run_mode_out,
    output logic diagnose_mode_enable_out,
    output logic [`TIMER_WIDTH-1:0] ring_timer_out
);
    import ring_mode_pkg::*;

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    // Odd parity bit for a byte: set when the data has even ones.
    function automatic logic odd_par(input logic [7:0] d);
        odd_par = ~(^d);
    endfunction

    // True when a byte and its parity bit together carry odd ones.
    function automatic logic par_ok(input par_byte_t b);
        par_ok = ^{b.parity, b.data};
    endfunction
    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    par_byte_t pind_s1, pind_s2;
    par_byte_t mreq_s1, mreq_s2;
    par_byte_t cbd_s1, cbd_s2;
    cbus_req_t cbr_s1, cbr_s2;
    logic mval_s1, mval_s2;

    // Two flops on every pin; only the second stage feeds logic.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pind_s1 <= '0;
            pind_s2 <= '0;
            mreq_s1 <= '0;
            mreq_s2 <= '0;
            cbd_s1 <= '0;
            cbd_s2 <= '0;
            cbr_s1 <= '0;
            cbr_s2 <= '0;
            mval_s1 <= 1'b0;
            mval_s2 <= 1'b0;
        end else if (clk_en_in) begin
            pind_s1 <= phy_indicate_data_pins_in;
            pind_s2 <= pind_s1;
            mreq_s1 <= mac_request_data_pins_in;
            mreq_s2 <= mreq_s1;
            cbd_s1 <= control_bus_data_pins_in;
            cbd_s2 <= cbd_s1;
            cbr_s1 <= cbus_req_in;
            cbr_s2 <= cbr_s1;
            mval_s1 <= mac_request_valid_in;
            mval_s2 <= mval_s1;
        end
    end
    // ------------------------------------------------------------
    // Control bus registers.
    // ------------------------------------------------------------
    logic [7:0] ring_engine_mode_reg;
    logic [7:0] option_reg;
    logic [7:0] exception_status_reg;
    logic [7:0] state_attention_reg;
    logic cb_wr_prev;
    logic wr_edge, wr_bad, wr_ok;
    logic run, loop_en;

    // A write acts once, on the first cycle the strobe is seen high.
    assign wr_edge = cbr_s2.wr && !cb_wr_prev;
    assign wr_bad = wr_edge && ring_engine_mode_reg[`MODE_CBUS_PAR_BIT]
        && !par_ok(cbd_s2);
    assign wr_ok = wr_edge && !wr_bad;
    assign run = ring_engine_mode_reg[`MODE_RUN_BIT];
    assign loop_en = ring_engine_mode_reg[`MODE_LOOP_BIT];

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cb_wr_prev <= 1'b0;
        end else if (clk_en_in) begin
            cb_wr_prev <= cbr_s2.wr;
        end
    end

    // Mode register; reserved bits stay zero.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ring_engine_mode_reg <= `MODE_RESET;
        end else if (clk_en_in && wr_ok
            && cbr_s2.addr == `MODE_REG_ADDR) begin
            ring_engine_mode_reg <= cbd_s2.data & `MODE_WRITE_MASK;
        end
    end

    // Option register, writable at any time, even while running.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            option_reg <= `OPTION_RESET;
        end else if (clk_en_in && wr_ok
            && cbr_s2.addr == `OPTION_REG_ADDR) begin
            option_reg <= cbd_s2.data;
        end
    end

    // Parity error flags: set wins over a clear written in the same cycle.
    // Writing a one to the flag clears it.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            exception_status_reg <= 8'h00;
            state_attention_reg <= 8'h00;
        end else if (clk_en_in) begin
            if (wr_bad && !cbr_s2.addr[`ADDR_BLOCK_BIT]) begin
                exception_status_reg[`CPE_BIT] <= 1'b1;
            end else if (wr_ok && cbr_s2.addr == `EXC_STATUS_ADDR
                && cbd_s2.data[`CPE_BIT]) begin
                exception_status_reg[`CPE_BIT] <= 1'b0;
            end
            if (wr_bad && cbr_s2.addr[`ADDR_BLOCK_BIT]) begin
                state_attention_reg[`CPE_BIT] <= 1'b1;
            end else if (wr_ok && cbr_s2.addr == `STATE_ATTN_ADDR
                && cbd_s2.data[`CPE_BIT]) begin
                state_attention_reg[`CPE_BIT] <= 1'b0;
            end
        end
    end

    // Read mux, registered, with odd parity always attached.
    logic [7:0] rd_mux;
    always_comb begin
        case (cbr_s2.addr)
            `MODE_REG_ADDR: rd_mux = ring_engine_mode_reg;
            `OPTION_REG_ADDR: rd_mux = option_reg;
            `EXC_STATUS_ADDR: rd_mux = exception_status_reg;
            `STATE_ATTN_ADDR: rd_mux = state_attention_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            control_bus_rdata_out <= '0;
            control_bus_data_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            control_bus_data_oe_out <= cbr_s2.rd;
            control_bus_rdata_out.data <= rd_mux;
            control_bus_rdata_out.parity <= odd_par(rd_mux);
        end
    end
    // ------------------------------------------------------------
    // Receive path: loopback, parity check, Idle substitution.
    // ------------------------------------------------------------
    par_byte_t rx_byte;
    logic rx_bad;
    // Loopback takes the request byte and ignores the PHY pins.
    assign rx_byte = loop_en ? phy_request_data_pins_out
        : pind_s2;
    assign rx_bad = ring_engine_mode_reg[`MODE_PIND_PAR_BIT]
        && !par_ok(rx_byte);

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mac_indicate_data_pins_out <= 9'h100; // Odd even in reset.
            code_violation_out <= 1'b0;
        end else if (clk_en_in) begin
            code_violation_out <= rx_bad;
            if (rx_bad) begin
                mac_indicate_data_pins_out.data <= `IDLE_BYTE;
                mac_indicate_data_pins_out.parity <= odd_par(`IDLE_BYTE);
            end else begin
                mac_indicate_data_pins_out.data <= rx_byte.data;
                // Regenerated, never copied, so it is always odd.
                mac_indicate_data_pins_out.parity <=
                    odd_par(rx_byte.data);
            end
        end
    end
    // ------------------------------------------------------------
    // Transmit sequencer and request path.
    // ------------------------------------------------------------
    tx_state_t tx_state;
    logic mreq_bad;
    assign mreq_bad = ring_engine_mode_reg[`MODE_MREQ_PAR_BIT]
        && mval_s2 && !par_ok(mreq_s2);

    // Stop mode parks the sequencer in its zero state.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_state <= TX_IDLE;
            tx_abort_out <= 1'b0;
        end else if (clk_en_in) begin
            tx_abort_out <= 1'b0;
            if (!run) begin
                tx_state <= TX_IDLE;
            end else begin
                case (tx_state)
                    TX_IDLE: if (mval_s2 && !mreq_bad) begin
                        tx_state <= TX_DATA;
                    end
                    TX_DATA: if (mreq_bad) begin
                        tx_state <= TX_END;
                        tx_abort_out <= 1'b1;
                    end else if (!mval_s2) begin
                        tx_state <= TX_END;
                    end
                    TX_END: tx_state <= TX_IDLE;
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end

    // Request byte: own data gets fresh parity, repeated data keeps its own.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            phy_request_data_pins_out.data <= `IDLE_BYTE;
            phy_request_data_pins_out.parity <= odd_par(`IDLE_BYTE);
        end else if (clk_en_in) begin
            if (!run) begin
                phy_request_data_pins_out.data <= `IDLE_BYTE;
                phy_request_data_pins_out.parity <= odd_par(`IDLE_BYTE);
            end else if (tx_state == TX_DATA && !mreq_bad) begin
                phy_request_data_pins_out.data <= mreq_s2.data;
                phy_request_data_pins_out.parity <=
                    odd_par(mreq_s2.data);
            end else if (rx_bad) begin
                phy_request_data_pins_out.data <= `IDLE_BYTE;
                phy_request_data_pins_out.parity <= odd_par(`IDLE_BYTE);
            end else begin
                phy_request_data_pins_out <= rx_byte;
            end
        end
    end
    // ------------------------------------------------------------
    // Ring timer and mode status outputs.
    // ------------------------------------------------------------
    // Free timer that only counts in run mode.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ring_timer_out <= '0;
        end else if (clk_en_in && run) begin
            ring_timer_out <= ring_timer_out + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            run_mode_out <= 1'b0;
            diagnose_mode_enable_out <= 1'b0;
        end else if (clk_en_in) begin
            run_mode_out <= run;
            diagnose_mode_enable_out <=
                ring_engine_mode_reg[`MODE_DIAGNOSE_MODE_ENABLE_BIT];
        end
    end
    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    // An abort pulse, then the sequencer back in its zero state.
    sequence s_abort_then_idle;
        tx_abort_out ##1 tx_state == TX_IDLE;
    endsequence
    property p_stop_idle;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && !run) |=> phy_request_data_pins_out.data == 8'hFF;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("Stop mode sent a non-Idle byte.");
    property p_stop_zero;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && !run) |=> tx_state == TX_IDLE;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("Sequencer left zero state in stop mode.");
    property p_timer_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !run |=> $stable(ring_timer_out);
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("Timer advanced in stop mode.");
    property p_mip_odd;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        1'b1 |-> ^mac_indicate_data_pins_out;
    endproperty
    a_mip_odd: assert property (p_mip_odd)
        else $error("MAC indicate parity not odd.");
    property p_read_par;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        control_bus_data_oe_out |-> ^control_bus_rdata_out;
    endproperty
    a_read_par: assert property (p_read_par)
        else $error("Read data parity not odd.");
    property p_bad_write_blocked;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_bad) |=> $stable(ring_engine_mode_reg)
            && $stable(option_reg);
    endproperty
    a_bad_write_blocked: assert property (p_bad_write_blocked)
        else $error("Write with bad parity changed a register.");
    property p_esr_flag;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_bad && !cbr_s2.addr[8]) |=> exception_status_reg[0];
    endproperty
    a_esr_flag: assert property (p_esr_flag)
        else $error("Exception status flag not set.");
    property p_state_attention_reg_flag;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_bad && cbr_s2.addr[8]) |=> state_attention_reg[0];
    endproperty
    a_state_attention_reg_flag: assert property (p_state_attention_reg_flag)
        else $error("State attention flag not set.");
    property p_rx_idle;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && rx_bad) |=> code_violation_out
            && mac_indicate_data_pins_out.data == 8'hFF;
    endproperty
    a_rx_idle: assert property (p_rx_idle)
        else $error("Bad indicate byte not replaced by Idle.");
    property p_abort;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (clk_en_in && run && tx_state == TX_DATA && mreq_bad) |=> s_abort_then_idle;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Request parity error did not abort.");
endmodule

/* File: verilog/ring_mode_pkg.sv */
// Types shared by the ring engine mode and parity control block.
// Assumes the constants header is on the include path.
`include "ring_mode_cfg.svh"
package ring_mode_pkg;
    // One parity-protected byte as it crosses a symbol or bus interface.
    typedef struct packed {
        logic parity;
        logic [7:0] data;
    } par_byte_t;

    // Control bus request fields, sampled together.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
    } cbus_req_t;

    // Transmit sequencer states; IDLE to DATA to END change one bit per step, END to IDLE two.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_END = 2'b11
    } tx_state_t;
endpackage
